// File: tb/spi_slave_model.sv
// Behavioural serial slave that swaps one byte per frame
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
   // Serial pins
   input wire logic sclk_i,
   input wire logic sel_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   // Frame shape and data
   input wire logic pol_i,
   input wire logic lsb_i,
   input wire logic [7:0] tx_i,
   output logic [7:0] rx_o
);
   int cnt; // Bits seen in this frame
   initial
   begin
      cnt = 0;
      miso_o = 1'b0;
      rx_o = 8'h00;
   end
   // Launch on the first edge of a period, capture on the second
   always @(sclk_i)
   begin
      if (!sel_n_i && sclk_i != pol_i && cnt < 8)
         miso_o = tx_i[lsb_i ? cnt : 7 - cnt];
      else if (!sel_n_i && sclk_i == pol_i && cnt < 8)
      begin
         rx_o[lsb_i ? cnt : 7 - cnt] = mosi_i;
         cnt = cnt + 1;
      end
   end
   // Released line flips, so a stale bit never passes as data
   always @(sel_n_i)
   begin
      cnt = 0;
      if (sel_n_i)
         miso_o = ~miso_o;
   end
endmodule : spi_slave_model
`default_nettype wire

// File: tb/tb_spi_master_controller.sv
// Self-checking bench of the serial master controller
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_controller;
   import spi_master_pkg::*;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   logic sfr_rd_i = 1'b0;
   logic [7:0] sfr_rdata_o;
   logic sdo, sclk, ss_n, irq_o, miso;
   logic pol = 1'b0; // Expected idle clock level
   logic lsb = 1'b0;
   logic auto_on = 1'b1; // Slave follows the select pin
   logic gnd_n = 1'b1; // Grounded select when auto is off
   logic [7:0] slv_tx = 8'h00;
   logic [7:0] slv_rx;
   logic [7:0] rd_q; // Last read data
   logic [7:0] last_rx = 8'h00;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   always #5 clock_i = ~clock_i;
   spi_master_controller i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
      .serial_in_pin_i(miso), .serial_out_pin_o(sdo),
      .serial_clock_out_o(sclk), .slave_select_out_o(ss_n), .irq_o(irq_o));
   spi_slave_model i_slave (.sclk_i(sclk),
      .sel_n_i(auto_on ? ss_n : gnd_n), .mosi_i(sdo), .miso_o(miso),
      .pol_i(pol), .lsb_i(lsb), .tx_i(slv_tx), .rx_o(slv_rx));
   ////////////////////////////////////////////////////////////////////
   // Compare one byte and count it
   task automatic check(input string what, input logic [7:0] e,
      input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : check
   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clock_i);
      sfr_wr_i <= 1'b0;
      #1;
   endtask : wr
   // Register read, data lands one cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge clock_i);
      sfr_rd_i <= 1'b0;
      #1 rd_q = sfr_rdata_o;
   endtask : rd
   ////////////////////////////////////////////////////////////////////
   // Reset values, unmapped reads and interrupt masking
   task automatic t_reset;
      logic [7:0] a [6] = '{8'hD2, 8'hD3, 8'hD6, 8'hD7, 8'hD0, 8'hD4};
      logic [7:0] e [6] = '{8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
      check("idle pins", 8'h01, {6'h00, sclk, ss_n});
      check("irq", 8'h00, {7'h00, irq_o});
      wr(ADDR_IRQ_EN, 8'h02);
      check("irq on", 8'h01, {7'h00, irq_o});
      wr(ADDR_IRQ_EN, 8'h01);
      check("irq mask", 8'h00, {7'h00, irq_o});
      wr(ADDR_IRQ_EN, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         rd(a[i]);
         check("reset reg", e[i], rd_q);
      end
      $display("test reset done");
   endtask : t_reset
   // Writable bits only, then back to reset values
   task automatic t_mask;
      logic [7:0] a [3] = '{8'hD2, 8'hD6, 8'hD7};
      logic [7:0] e [3] = '{8'hFC, 8'h7E, 8'h0F};
      logic [7:0] r [3] = '{8'h04, 8'h00, 8'h00};
      for (int i = 0; i < 3; i++)
      begin
         wr(a[i], 8'hFF);
         rd(a[i]);
         check("mask", e[i], rd_q);
         wr(a[i], r[i]);
      end
      $display("test mask done");
   endtask : t_mask
   // One frame: clock shape, select, data both ways, flags
   task automatic t_frame(input logic [7:0] dv, ctl, mo, mi, st);
      int n, t1, per, bad, d;
      logic was;
      n = 0;
      t1 = 0;
      per = 0;
      bad = 0;
      d = (dv[7:2] == 0) ? 4 : dv[7:2] * 4;
      rd(ADDR_STATUS);
      wr(ADDR_CLK_DIV, dv);
      pol = ctl[CTRL_POL];
      lsb = ctl[CTRL_LSB_FIRST];
      auto_on = ctl[CTRL_AUTO_SEL];
      slv_tx = mi;
      wr(ADDR_CTRL, ctl);
      wr(ADDR_TX_HOLD, mo);
      // Ground select late, so the polarity switch is no clock edge
      gnd_n = 1'b0;
      was = pol;
      // Frame lasts eight and a half divisor periods; spare cycles catch extra pulses
      repeat (9 * d + 10)
      begin
         @(posedge clock_i);
         #1;
         if (sclk !== was && sclk !== pol)
         begin
            n++;
            if (n == 1)
               t1 = cycles;
            if (n == 2)
               per = cycles - t1;
         end
         if (sclk !== pol && ss_n !== !auto_on)
            bad++;
         was = sclk;
      end
      gnd_n = 1'b1;
      check("launches", 8'h08, 8'(n));
      check("period", 8'(d), 8'(per));
      check("select", 8'h00, 8'(bad));
      check("slave rx", mo, slv_rx);
      check("idle clk", {7'h00, pol}, {7'h00, sclk});
      if (ctl[CTRL_RX_EN])
         last_rx = mi;
      rd(ADDR_RX_HOLD);
      check("rx hold", last_rx, rd_q);
      rd(ADDR_STATUS);
      check("status", st, rd_q);
      rd(ADDR_STATUS);
      check("cleared", 8'h00, rd_q);
      $display("test frame %h done", ctl);
   endtask : t_frame
   // Block off holds the byte; losing transmit enable aborts a frame
   task automatic t_abort;
      int n, bad;
      logic was;
      n = 0;
      bad = 0;
      pol = 1'b0;
      auto_on = 1'b1;
      wr(ADDR_CLK_DIV, 8'hFC);
      wr(ADDR_CTRL, 8'h48);
      wr(ADDR_TX_HOLD, 8'h5A);
      repeat (40) @(posedge clock_i);
      check("off clk", 8'h00, {7'h00, sclk});
      rd(ADDR_STATUS);
      check("off status", 8'h00, rd_q);
      wr(ADDR_CTRL, 8'h78);
      was = sclk;
      repeat (2000)
      begin
         @(posedge clock_i);
         #1;
         if (sclk === 1'b1 && was === 1'b0)
            n++;
         was = sclk;
         if (n == 3)
            break;
      end
      wr(ADDR_CTRL, 8'h38);
      repeat (600)
      begin
         @(posedge clock_i);
         #1;
         if (sclk !== 1'b0 || ss_n !== 1'b1)
            bad++;
      end
      check("abort idle", 8'h00, 8'(bad));
      rd(ADDR_STATUS);
      check("abort flags", 8'h02, rd_q);
      $display("test abort done");
   endtask : t_abort
   // Two frames back to back with no read between: overrun
   task automatic t_b2b;
      wr(ADDR_CLK_DIV, 8'h04);
      rd(ADDR_RX_HOLD);
      rd(ADDR_STATUS);
      wr(ADDR_IRQ_EN, 8'h0F);
      slv_tx = 8'hC3;
      wr(ADDR_CTRL, 8'h78);
      wr(ADDR_TX_HOLD, 8'h11);
      wr(ADDR_TX_HOLD, 8'h22);
      @(posedge ss_n);
      slv_tx = 8'h3C;
      repeat (60) @(posedge clock_i);
      #1;
      check("slave rx 2", 8'h22, slv_rx);
      check("irq", 8'h01, {7'h00, irq_o});
      rd(ADDR_STATUS);
      check("b2b flags", 8'h0F, rd_q);
      check("irq clr", 8'h00, {7'h00, irq_o});
      rd(ADDR_RX_HOLD);
      check("newest", 8'h3C, rd_q);
      wr(ADDR_IRQ_EN, 8'h00);
      $display("test back to back done");
   endtask : t_b2b
   // Reset in mid-frame returns registers and pins to reset state
   task automatic t_rerun;
      logic [7:0] a [4] = '{8'hD2, 8'hD3, 8'hD6, 8'hD7};
      logic [7:0] e [4] = '{8'h04, 8'h02, 8'h00, 8'h00};
      wr(ADDR_CLK_DIV, 8'hFC);
      wr(ADDR_IRQ_EN, 8'h0F);
      wr(ADDR_CTRL, 8'h7E);
      wr(ADDR_TX_HOLD, 8'h66);
      repeat (20) @(posedge clock_i);
      reset_n_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      check("reset pins", 8'h02, {5'h00, sclk, ss_n, irq_o});
      reset_n_i <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         rd(a[i]);
         check("rerun reg", e[i], rd_q);
      end
      $display("test mid reset done");
   endtask : t_rerun
   ////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic complete_run;
      $display("counts %0d checks %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   // Hang guard, well above the longest expected run
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         complete_run;
      end
   end
   // Main sequence
   initial
   begin
      repeat (5) @(posedge clock_i);
      reset_n_i <= 1'b1;
      t_reset;
      t_mask;
      t_frame(8'h04, 8'h78, 8'hA5, 8'h3C, 8'h0B);
      t_frame(8'h24, 8'h7E, 8'h81, 8'h96, 8'h0B);
      t_frame(8'hFC, 8'h74, 8'hC6, 8'h5D, 8'h0B);
      t_frame(8'h08, 8'h5A, 8'h0F, 8'hF0, 8'h0A);
      t_abort;
      t_b2b;
      t_rerun;
      complete_run;
   end
endmodule : tb_spi_master_controller
`default_nettype wire

// File: verilog/spi_clk_div.sv
// Half-period tick generator for the serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_clk_div
   import spi_master_pkg::*;
#(
   parameter int SEL_W = DIV_SEL_W
)(
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Control
   input wire logic run_i,
   input wire logic [SEL_W-1:0] div_sel_i,
   // Tick out
   output logic tick_o
);
   if (SEL_W < 1)
   begin : g_bad_width
      $error("divider select width must be at least one");
   end
   logic [SEL_W:0] half_w; // Cycles per half serial period
   logic [SEL_W:0] cnt_q; // Cycle counter
   logic last_w; // Counter at end of half period
   // Divisor is four times the select, so half is twice it; zero acts as a select of one
   assign half_w = (div_sel_i == '0) ? (SEL_W+1)'(2) : {div_sel_i, 1'b0};
   // Compare with >= so a divider change mid-count cannot overshoot
   assign last_w = cnt_q >= (half_w - (SEL_W+1)'(1));
   assign tick_o = run_i && last_w;
   // Counter restarts whenever the sequencer is idle
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cnt_q <= '0;
      else if (!run_i || last_w)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + (SEL_W+1)'(1);
   end
   tick_gap_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      tick_o |=> !tick_o) else $error("tick came twice in a row");
endmodule : spi_clk_div
`default_nettype wire

// File: verilog/spi_master_controller.sv
// Serial master top: register file, transfer sequencer, flags, pins
`timescale 1ns/1ps
`default_nettype none
module spi_master_controller
   import spi_master_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Special function register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   // Serial pins
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic serial_clock_out_o,
   output logic slave_select_out_o,
   // Interrupt request to the processor
   output logic irq_o
);
   localparam int BITS_PER_FRAME = FRAME_BITS;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] ctrl_q; // Main control register
   logic [7:0] irq_en_q; // Interrupt enable register
   logic [7:0] clk_div_q; // Clock divider register
   logic [7:0] tx_hold_q; // Transmit holding byte
   logic tx_full_q; // Transmit holding occupied
   logic [7:0] rx_hold_q; // Receive holding byte
   logic rx_full_q; // Receive holding unread
   logic [3:0] flags_q; // Sticky cause flags
   logic [3:0] flags_d; // Next cause flags
   logic [7:0] rdata_q; // Registered read data
   state_t state_q; // Sequencer state
   state_t state_d; // Next sequencer state
   logic [2:0] bit_cnt_q; // Bits sampled this frame
   logic sclk_q; // Serial clock level
   logic ss_q; // Select level, active low
   logic [3:0] samp_cnt_q; // Sample pulses since load

   // Decoded bus strobes
   logic wr_ctrl_w;
   logic wr_irq_en_w;
   logic wr_clk_div_w;
   logic wr_tx_w;
   logic rd_status_w;
   logic rd_rx_w;
   // Control fields
   logic pol_w;
   logic lsb_w;
   logic auto_sel_w;
   logic run_ok_w;
   logic rx_en_w;
   // Sequencer events
   logic tick_w;
   logic start_w;
   logic done_w;
   logic abort_w;
   logic [7:0] status_w;
   logic [7:0] rd_mux_w;
   logic [3:0] set_w;

   spi_shift_if #(.WIDTH(FRAME_BITS)) shx ();

   // Address match used by every strobe
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign wr_ctrl_w = sfr_wr_i && hit(sfr_addr_i, ADDR_CTRL);
   assign wr_irq_en_w = sfr_wr_i && hit(sfr_addr_i, ADDR_IRQ_EN);
   assign wr_clk_div_w = sfr_wr_i && hit(sfr_addr_i, ADDR_CLK_DIV);
   assign wr_tx_w = sfr_wr_i && hit(sfr_addr_i, ADDR_TX_HOLD);
   assign rd_status_w = sfr_rd_i && hit(sfr_addr_i, ADDR_STATUS);
   assign rd_rx_w = sfr_rd_i && hit(sfr_addr_i, ADDR_RX_HOLD);

   // Control fields
   assign pol_w = ctrl_q[CTRL_POL];
   assign lsb_w = ctrl_q[CTRL_LSB_FIRST];
   assign auto_sel_w = ctrl_q[CTRL_AUTO_SEL];
   assign rx_en_w = ctrl_q[CTRL_RX_EN];
   // Shifting needs both the block and the transmitter on
   assign run_ok_w = ctrl_q[CTRL_BLOCK_ON] && ctrl_q[CTRL_TX_EN];

   // Status image, busy is live
   assign status_w = {3'h0, state_q != ST_IDLE, flags_q};

   // Read selection; transmit holding is write-only and reads zero
   assign rd_mux_w = hit(sfr_addr_i, ADDR_CTRL) ? ctrl_q :
                     hit(sfr_addr_i, ADDR_IRQ_EN) ? irq_en_q :
                     hit(sfr_addr_i, ADDR_CLK_DIV) ? clk_div_q :
                     hit(sfr_addr_i, ADDR_STATUS) ? status_w :
                     hit(sfr_addr_i, ADDR_RX_HOLD) ? rx_hold_q :
                     8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   // Writable bits only; reserved bits stay zero
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_q <= CTRL_RESET;
         irq_en_q <= IRQ_EN_RESET;
         clk_div_q <= CLK_DIV_RESET;
      end
      else
      begin
         if (wr_ctrl_w)
            ctrl_q <= sfr_wdata_i & CTRL_MASK;
         if (wr_irq_en_w)
            irq_en_q <= sfr_wdata_i & IRQ_EN_MASK;
         if (wr_clk_div_w)
            clk_div_q <= sfr_wdata_i & CLK_DIV_MASK;
      end
   end

   // Read data is registered on the read strobe
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rdata_q <= 8'h00;
      else if (sfr_rd_i)
         rdata_q <= rd_mux_w;
   end
   assign sfr_rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Holding buffers
   // Start needs a byte waiting and an idle sequencer
   assign start_w = (state_q == ST_IDLE) && run_ok_w && tx_full_q;
   // Frame completes on the tick that ends the trailing half period
   assign done_w = (state_q == ST_TRAIL) && tick_w;
   // Losing the enables drops the frame at once
   assign abort_w = (state_q != ST_IDLE) && !run_ok_w;

   // A write in the load cycle wins, so that byte is not lost
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         tx_hold_q <= 8'h00;
         tx_full_q <= 1'b0;
      end
      else
      begin
         if (wr_tx_w)
            tx_hold_q <= sfr_wdata_i;
         tx_full_q <= wr_tx_w || (tx_full_q && !start_w);
      end
   end

   // Overrun keeps the newest byte; reading clears unread, new byte wins
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rx_hold_q <= 8'h00;
         rx_full_q <= 1'b0;
      end
      else
      begin
         if (done_w && rx_en_w)
            rx_hold_q <= shx.shift_byte;
         rx_full_q <= (done_w && rx_en_w) || (rx_full_q && !rd_rx_w);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cause flags and interrupt
   // Hardware set wins over the clear by a status read
   assign set_w[FLAG_TX_END] = done_w && !tx_full_q;
   assign set_w[FLAG_OVERRUN] = done_w && rx_en_w && rx_full_q;
   assign set_w[FLAG_TX_EMPTY] = start_w;
   assign set_w[FLAG_RX_FULL] = done_w && rx_en_w;
   assign flags_d = set_w | (flags_q & ~{4{rd_status_w}});

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         flags_q <= FLAGS_RESET;
      else
         flags_q <= flags_d;
   end

   // One request line for all enabled causes
   assign irq_o = |(flags_q & irq_en_q[3:0]);

   ////////////////////////////////////////////////////////////////////////
   // Clock divider and shifter
   spi_clk_div #(.SEL_W(DIV_SEL_W)) u_div (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .run_i(state_q != ST_IDLE),
      .div_sel_i(clk_div_q[DIV_SEL_LSB +: DIV_SEL_W]),
      .tick_o(tick_w)
   );

   spi_shifter #(.WIDTH(FRAME_BITS)) u_shift (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .sh(shx.shifter)
   );

   assign shx.load = start_w;
   assign shx.load_byte = tx_hold_q;
   assign shx.lsb_first = lsb_w;
   assign shx.serial_in = serial_in_pin_i;
   // Launch on the first edge of every bit period
   assign shx.launch = tick_w && !abort_w &&
      (state_q == ST_LEAD || state_q == ST_SECOND);
   // Sample on the second edge
   assign shx.sample = tick_w && !abort_w && (state_q == ST_FIRST);

   ////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   // Next state on each half-period tick; idle leaves on start, abort returns to idle at once
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (start_w)
               state_d = ST_LEAD;
         ST_LEAD:
            if (tick_w)
               state_d = ST_FIRST;
         ST_FIRST:
            if (tick_w)
               state_d = (bit_cnt_q == 3'(BITS_PER_FRAME - 1)) ?
                         ST_TRAIL : ST_SECOND;
         ST_SECOND:
            if (tick_w)
               state_d = ST_FIRST;
         ST_TRAIL:
            if (tick_w)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
      if (abort_w)
         state_d = ST_IDLE;
   end

   // State, bit count, clock level and select
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 3'h0;
         sclk_q <= 1'b0;
         ss_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         if (start_w)
            bit_cnt_q <= 3'h0;
         else if (shx.sample)
            bit_cnt_q <= bit_cnt_q + 3'h1;
         // Active level on launch, idle level otherwise
         if (shx.launch)
            sclk_q <= !pol_w;
         else if (shx.sample || state_q == ST_IDLE || abort_w)
            sclk_q <= pol_w;
         // Select is sampled once per frame, so clearing waits for the end
         if (start_w)
            ss_q <= !auto_sel_w;
         else if (done_w || abort_w || state_q == ST_IDLE)
            ss_q <= 1'b1;
      end
   end

   assign serial_clock_out_o = sclk_q;
   assign slave_select_out_o = ss_q;
   assign serial_out_pin_o = shx.out_bit;

   // Sample count since load, read by checks only
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         samp_cnt_q <= 4'h0;
      else if (start_w)
         samp_cnt_q <= 4'h0;
      else if (shx.sample)
         samp_cnt_q <= samp_cnt_q + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_start_auto;
      start_w && auto_sel_w;
   endsequence
   sequence s_frame_end;
      done_w && !abort_w;
   endsequence
   idle_clock_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state_q == ST_IDLE && $past(state_q == ST_IDLE)) |->
      sclk_q == $past(pol_w)) else $error("clock not idle");
   launch_level_a: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      shx.launch |=> sclk_q != $past(pol_w))
      else $error("launch edge wrong");
   sample_level_a: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      shx.sample |=> sclk_q == $past(pol_w))
      else $error("sample edge wrong");
   select_low_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_start_auto |=> !ss_q ##1 !ss_q)
      else $error("select not asserted");
   select_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state_q == ST_IDLE && $past(state_q == ST_IDLE)) |-> ss_q)
      else $error("select low while idle");
   eight_bits_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_frame_end |-> samp_cnt_q == 4'(BITS_PER_FRAME))
      else $error("frame bit count wrong");
   tx_end_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (s_frame_end and !tx_full_q) |=> flags_q[FLAG_TX_END])
      else $error("transmission end missed");
   overrun_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (s_frame_end and (rx_en_w && rx_full_q)) |=> flags_q[FLAG_OVERRUN])
      else $error("overrun missed");
   status_clear_a: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (rd_status_w && set_w == 4'h0) |=> flags_q == 4'h0)
      else $error("flags not cleared by read");
   stop_clock_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      abort_w |=> state_q == ST_IDLE ##1 sclk_q == $past(pol_w, 2))
      else $error("disable did not stop clock");
endmodule : spi_master_controller
`default_nettype wire

// File: verilog/spi_master_pkg.sv
// Shared constants, register map and state type of the serial master
package spi_master_pkg;
   // Register addresses on the special function bus
   localparam logic [7:0] ADDR_CLK_DIV = 8'hD2;
   localparam logic [7:0] ADDR_STATUS = 8'hD3;
   localparam logic [7:0] ADDR_TX_HOLD = 8'hD4;
   localparam logic [7:0] ADDR_RX_HOLD = 8'hD5;
   localparam logic [7:0] ADDR_CTRL = 8'hD6;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hD7;
   // Main control bit positions
   localparam int CTRL_TX_EN = 6;
   localparam int CTRL_RX_EN = 5;
   localparam int CTRL_BLOCK_ON = 4;
   localparam int CTRL_AUTO_SEL = 3;
   localparam int CTRL_LSB_FIRST = 2;
   localparam int CTRL_POL = 1;
   // Reset values and writable masks
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'h7E;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] IRQ_EN_MASK = 8'h0F;
   localparam logic [7:0] CLK_DIV_RESET = 8'h04;
   localparam logic [7:0] CLK_DIV_MASK = 8'hFC;
   localparam logic [3:0] FLAGS_RESET = 4'h2;
   // Status bit positions
   localparam int STATUS_BUSY = 4;
   localparam int FLAG_TX_END = 3;
   localparam int FLAG_OVERRUN = 2;
   localparam int FLAG_TX_EMPTY = 1;
   localparam int FLAG_RX_FULL = 0;
   // Frame and divider shape
   localparam int FRAME_BITS = 8;
   localparam int DIV_SEL_LSB = 2;
   localparam int DIV_SEL_W = 6;
   // Transfer sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_FIRST,
      ST_SECOND,
      ST_TRAIL
   } state_t;
endpackage : spi_master_pkg

// File: verilog/spi_shift_if.sv
// Carrier between the transfer sequencer and the data shifter
`timescale 1ns/1ps
`default_nettype none
interface spi_shift_if #(parameter int WIDTH = 8);
   logic load; // Take a new byte into the shifter
   logic launch; // Present the next bit on the line
   logic sample; // Shift the incoming bit in
   logic lsb_first; // Bit order select
   logic serial_in; // Incoming line level
   logic [WIDTH-1:0] load_byte; // Byte to send
   logic [WIDTH-1:0] shift_byte; // Shifter contents
   logic out_bit; // Registered outgoing bit
   modport ctrl (output load, launch, sample, lsb_first, serial_in,
      load_byte, input shift_byte, out_bit);
   modport shifter (input load, launch, sample, lsb_first, serial_in,
      load_byte, output shift_byte, out_bit);
endinterface : spi_shift_if
`default_nettype wire

// File: verilog/spi_shifter.sv
// Data shift register with selectable bit order
`timescale 1ns/1ps
`default_nettype none
module spi_shifter #(
   parameter int WIDTH = 8
)(
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Sequencer side
   spi_shift_if.shifter sh
);
   if (WIDTH < 2)
   begin : g_bad_width
      $error("shifter width must be at least two");
   end
   logic [WIDTH-1:0] sh_q; // Shift register
   logic out_q; // Outgoing bit
   logic [WIDTH-1:0] shifted_w; // Next value after a sample
   assign shifted_w = sh.lsb_first ? {sh.serial_in, sh_q[WIDTH-1:1]}
                                   : {sh_q[WIDTH-2:0], sh.serial_in};
   assign sh.shift_byte = sh_q;
   assign sh.out_bit = out_q;
   // Load, launch and sample never coincide
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sh_q <= '0;
         out_q <= 1'b0;
      end
      else
      begin
         if (sh.load)
            sh_q <= sh.load_byte;
         else if (sh.sample)
            sh_q <= shifted_w;
         if (sh.launch)
            out_q <= sh.lsb_first ? sh_q[0] : sh_q[WIDTH-1];
      end
   end
   msb_order_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (sh.sample && !sh.load && !sh.lsb_first) |=>
      sh_q[0] == $past(sh.serial_in))
      else $error("msb-first sample landed wrong");
endmodule : spi_shifter
`default_nettype wire
